//--- hdl/mtr_defs.svh
// register map, field positions and timing constants of the monitor register bank
`ifndef MTR_DEFS_SVH
`define MTR_DEFS_SVH

// five-bit host address codes
`define MTR_A_CTRL 5'h00
`define MTR_A_STAT 5'h01
`define MTR_A_BLKP 5'h02
`define MTR_A_LCMD 5'h05
`define MTR_A_LOGP 5'h06
`define MTR_A_UEN 5'h07
`define MTR_A_UFLG 5'h08
`define MTR_A_NEN 5'h09
`define MTR_A_TADR 5'h0a
`define MTR_A_BIT 5'h0b
`define MTR_A_PRST 5'h0c
`define MTR_A_TCLR 5'h0d
`define MTR_A_MCTL 5'h0e
`define MTR_A_MSKL 5'h10
`define MTR_A_MSKH 5'h11

// mode_control fields
`define MTR_C_TIMEOUT 12
`define MTR_C_EXTOVR 11
`define MTR_C_ROLE 10
`define MTR_C_CHB 8
`define MTR_C_CHA 7
`define MTR_C_START 0

// operating_status fields
`define MTR_S_MON 15
`define MTR_S_BIT 14
`define MTR_S_RST 13
`define MTR_S_ROLE 12
`define MTR_S_CHA 11
`define MTR_S_SFAIL 10

// monitor_control fields
`define MTR_M_SEL 15
`define MTR_M_ALL 14
`define MTR_M_SELT 13

// implemented bits of the event, monitor control and terminal address registers
`define MTR_UEN_MASK 16'h013b
`define MTR_NEN_MASK 16'h0003
`define MTR_MCTL_MASK 16'he000
`define MTR_TADR_MODE 8
`define MTR_TADR_LOCK 7

// reset value and log pointer stride
`define MTR_WORD_RST 16'h0000
`define MTR_LOG_STRIDE 16'h0003

// timing
`define MTR_CLK_MHZ 250
`define MTR_BIT_US 100
`define MTR_PRST_US 1
`define MTR_BIT_CYCLES (`MTR_BIT_US * `MTR_CLK_MHZ)
`define MTR_PRST_CYCLES (`MTR_PRST_US * `MTR_CLK_MHZ)

`endif

//--- hdl/mtr_pkg.sv
// types shared by the monitor register bank
package mtr_pkg;
  typedef logic [15:0] mtr_word_t;
  typedef logic [4:0] mtr_addr_t;
endpackage : mtr_pkg

//--- hdl/mtr_countdown.sv
// one-shot busy timer for built-in test and programmed reset routines
`timescale 1ns/100ps
module mtr_countdown #(
  parameter int CYCLES = 250
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  output logic busy
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] count;

  if (CYCLES < 1)
  begin : g_chk
    $error("mtr_countdown needs at least one cycle");
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= '0;
      busy <= 1'b0;
    end
    else if (abort)
    begin
      count <= '0;
      busy <= 1'b0;
    end
    else if (start)
    begin
      count <= W'(CYCLES - 1);
      busy <= 1'b1;
    end
    else if (busy)
    begin
      count <= count - W'(1);
      busy <= (count != '0);
    end
  end
endmodule : mtr_countdown

//--- hdl/mtr_regs.sv
// host register bank for the bus-watcher mode of the bus controller/terminal/monitor
`timescale 1ns/100ps
`include "mtr_defs.svh"

// Functional notes
// - event log pointer at 00110, last command 00101
// - watch masks at codes 10000 and 10001
// - control selects role, channels, timeout, override
// - programmed reset clears start, keeps other bits
// - status read-only: monitor, test, reset, role, channel, fail
// - programmed reset clears urgent flags, keeps fail, channel shows A
// - block pointer read/write, auto-updated, kept by programmed reset
// - last command read-only, captured per executed command
// - host loads log pointer, device advances it
module mtr_regs
  import mtr_pkg::*;
#(
  parameter int BIT_CYCLES = `MTR_BIT_CYCLES,
  parameter int PRST_CYCLES = `MTR_PRST_CYCLES,
  parameter mtr_word_t LOG_STRIDE = `MTR_LOG_STRIDE
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire mtr_addr_t host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire mtr_word_t host_wdata,
  output mtr_word_t host_rdata,
  input wire logic cmd_exec,
  input wire mtr_word_t cmd_word,
  input wire mtr_word_t cmd_block_next,
  input wire logic log_entry_done,
  input wire mtr_word_t urgent_evt,
  input wire logic chan_a_active,
  input wire logic subsys_fail,
  input wire logic mode_select_pin,
  input wire logic lock_pin,
  output logic start_enable,
  output logic role_select,
  output logic chan_a_enable,
  output logic chan_b_enable,
  output logic bc_timeout,
  output logic ext_override,
  output logic bus_watcher_select,
  output logic watch_all,
  output logic watch_selected,
  output mtr_word_t watch_mask_lo,
  output mtr_word_t watch_mask_hi,
  output logic self_test_busy,
  output logic soft_reset_busy,
  output logic timer_clear
);
  if (BIT_CYCLES < 1 || PRST_CYCLES < 1 || LOG_STRIDE == 16'h0000)
  begin : g_chk
    $error("mtr_regs parameters out of range");
  end

  logic rst_meta;
  logic rst_n;
  mtr_word_t current_block_pointer;
  mtr_word_t last_bus_command;
  mtr_word_t event_log_pointer;
  mtr_word_t urgent_event_enable;
  mtr_word_t urgent_event_flags;
  mtr_word_t normal_event_enable;
  logic mon_act;
  logic chan_a_stat;
  logic sfail_stat;
  logic test_busy;
  logic prst_busy;

  // two-flop release of the asynchronous reset
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // address decode
  wire wr_ctrl = host_wr && (host_addr == `MTR_A_CTRL);
  wire wr_blkp = host_wr && (host_addr == `MTR_A_BLKP);
  wire wr_logp = host_wr && (host_addr == `MTR_A_LOGP);
  wire wr_uen = host_wr && (host_addr == `MTR_A_UEN);
  wire wr_uflg = host_wr && (host_addr == `MTR_A_UFLG);
  wire wr_nen = host_wr && (host_addr == `MTR_A_NEN);
  wire wr_mctl = host_wr && (host_addr == `MTR_A_MCTL);
  wire wr_mskl = host_wr && (host_addr == `MTR_A_MSKL);
  wire wr_mskh = host_wr && (host_addr == `MTR_A_MSKH);
  wire wr_tclr = host_wr && (host_addr == `MTR_A_TCLR);
  wire any_data = (host_wdata != 16'h0000);
  wire bit_go = host_wr && (host_addr == `MTR_A_BIT) && any_data;
  wire prst_go = host_wr && (host_addr == `MTR_A_PRST) && any_data;

  // monitor starts when launched as non-controller with watcher selected
  wire mon_go = wr_ctrl && host_wdata[`MTR_C_START] && !host_wdata[`MTR_C_ROLE]
    && bus_watcher_select;
  wire mon_stop = prst_go || (wr_ctrl && !host_wdata[`MTR_C_START]);

  // readback words; write-only bits read as zero
  wire mtr_word_t ctrl_word = {3'b000, bc_timeout, ext_override, 2'b00,
    chan_b_enable, chan_a_enable, 7'h00};
  wire mtr_word_t status_word = {mon_act, test_busy, prst_busy, role_select,
    chan_a_stat, sfail_stat, 10'h000};
  wire mtr_word_t mctl_word = {bus_watcher_select, watch_all, watch_selected, 13'h0000};
  wire mtr_word_t tadr_word = {7'h00, mode_select_pin, lock_pin, 7'h00};

  wire mtr_word_t read_mux =
    (host_addr == `MTR_A_CTRL) ? ctrl_word :
    (host_addr == `MTR_A_STAT) ? status_word :
    (host_addr == `MTR_A_BLKP) ? current_block_pointer :
    (host_addr == `MTR_A_LCMD) ? last_bus_command :
    (host_addr == `MTR_A_LOGP) ? event_log_pointer :
    (host_addr == `MTR_A_UEN) ? urgent_event_enable :
    (host_addr == `MTR_A_UFLG) ? urgent_event_flags :
    (host_addr == `MTR_A_NEN) ? normal_event_enable :
    (host_addr == `MTR_A_TADR) ? tadr_word :
    (host_addr == `MTR_A_MCTL) ? mctl_word :
    (host_addr == `MTR_A_MSKL) ? watch_mask_lo :
    (host_addr == `MTR_A_MSKH) ? watch_mask_hi :
    16'h0000;

  // event flags: a new event outranks a write-one clear
  wire mtr_word_t next_uflg = (urgent_event_flags & ~(wr_uflg ? host_wdata : 16'h0000))
    | (urgent_evt & `MTR_UEN_MASK);

  // pointer updates; device advance applies only once running
  wire log_step = log_entry_done && start_enable;
  wire mtr_word_t next_logp = wr_logp ? host_wdata :
    (event_log_pointer + LOG_STRIDE);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      host_rdata <= `MTR_WORD_RST;
    else if (host_rd)
      host_rdata <= read_mux;
  end

  // control register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_enable <= 1'b0;
      role_select <= 1'b0;
      chan_a_enable <= 1'b0;
      chan_b_enable <= 1'b0;
      bc_timeout <= 1'b0;
      ext_override <= 1'b0;
    end
    else if (prst_go)
      start_enable <= 1'b0;
    else if (wr_ctrl)
    begin
      start_enable <= host_wdata[`MTR_C_START];
      role_select <= host_wdata[`MTR_C_ROLE];
      chan_a_enable <= host_wdata[`MTR_C_CHA];
      chan_b_enable <= host_wdata[`MTR_C_CHB];
      bc_timeout <= host_wdata[`MTR_C_TIMEOUT];
      ext_override <= host_wdata[`MTR_C_EXTOVR];
    end
  end

  // status flags
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mon_act <= 1'b0;
      chan_a_stat <= 1'b1;
      sfail_stat <= 1'b0;
    end
    else
    begin
      mon_act <= mon_go || (mon_act && !mon_stop);
      if (prst_go)
        chan_a_stat <= 1'b1;
      else if (cmd_exec)
        chan_a_stat <= chan_a_active;
      sfail_stat <= sfail_stat || subsys_fail;
    end
  end

  // auto-updating pointers and captured command
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      current_block_pointer <= `MTR_WORD_RST;
      last_bus_command <= `MTR_WORD_RST;
      event_log_pointer <= `MTR_WORD_RST;
    end
    else
    begin
      if (cmd_exec)
        current_block_pointer <= cmd_block_next;
      else if (wr_blkp)
        current_block_pointer <= host_wdata;
      if (cmd_exec)
        last_bus_command <= cmd_word;
      if (wr_logp || log_step)
        event_log_pointer <= next_logp;
    end
  end

  // event enables, flags, watcher configuration
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      urgent_event_enable <= `MTR_WORD_RST;
      urgent_event_flags <= `MTR_WORD_RST;
      normal_event_enable <= `MTR_WORD_RST;
      bus_watcher_select <= 1'b0;
      watch_all <= 1'b0;
      watch_selected <= 1'b0;
      watch_mask_lo <= `MTR_WORD_RST;
      watch_mask_hi <= `MTR_WORD_RST;
      timer_clear <= 1'b0;
    end
    else
    begin
      timer_clear <= wr_tclr;
      urgent_event_flags <= prst_go ? `MTR_WORD_RST : next_uflg;
      if (wr_uen)
        urgent_event_enable <= host_wdata & `MTR_UEN_MASK;
      if (wr_nen)
        normal_event_enable <= host_wdata & `MTR_NEN_MASK;
      if (wr_mctl)
      begin
        bus_watcher_select <= host_wdata[`MTR_M_SEL];
        watch_all <= host_wdata[`MTR_M_ALL];
        watch_selected <= host_wdata[`MTR_M_SELT];
      end
      if (prst_go)
      begin
        watch_mask_lo <= `MTR_WORD_RST;
        watch_mask_hi <= `MTR_WORD_RST;
      end
      else
      begin
        if (wr_mskl)
          watch_mask_lo <= host_wdata;
        if (wr_mskh)
          watch_mask_hi <= host_wdata;
      end
    end
  end

  // built-in test and programmed reset routines
  mtr_countdown #(
    .CYCLES(BIT_CYCLES)
  ) u_test_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(bit_go && !prst_go),
    .abort(prst_go),
    .busy(test_busy)
  );

  mtr_countdown #(
    .CYCLES(PRST_CYCLES)
  ) u_prst_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(prst_go),
    .abort(1'b0),
    .busy(prst_busy)
  );

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      self_test_busy <= 1'b0;
      soft_reset_busy <= 1'b0;
    end
    else
    begin
      self_test_busy <= test_busy;
      soft_reset_busy <= prst_busy;
    end
  end

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_logp_read;
    host_rd && (host_addr == 5'h06) |=> host_rdata == $past(event_log_pointer);
  endproperty
  a_logp_read: assert property (p_logp_read)
    else $error("log pointer read mismatch");
  property p_lcmd_read;
    host_rd && (host_addr == 5'h05) |=> host_rdata == $past(last_bus_command);
  endproperty
  a_lcmd_read: assert property (p_lcmd_read)
    else $error("last command read mismatch");
  property p_mask_write;
    wr_mskh && !prst_go ##1 !wr_mskh && !prst_go
      ##1 host_rd && (host_addr == 5'h11)
      |=> host_rdata == $past(host_wdata, 3);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("high watch mask did not read back");
  property p_ctrl_write;
    wr_ctrl && !prst_go |=> chan_a_enable == $past(host_wdata[7])
      && chan_b_enable == $past(host_wdata[8]) && role_select == $past(host_wdata[10]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control fields not taken");
  property p_prst_start;
    prst_go |=> !start_enable && $stable(bc_timeout) && $stable(chan_a_enable)
      && $stable(role_select);
  endproperty
  a_prst_start: assert property (p_prst_start)
    else $error("programmed reset control bits wrong");
  property p_stat_read;
    host_rd && (host_addr == 5'h01) |=> host_rdata == $past(status_word);
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status read mismatch");
  property p_prst_status;
    prst_go |=> !mon_act && chan_a_stat && !test_busy
      && sfail_stat == $past(sfail_stat || subsys_fail);
  endproperty
  a_prst_status: assert property (p_prst_status)
    else $error("programmed reset status wrong");
  property p_blkp_update;
    cmd_exec |=> current_block_pointer == $past(cmd_block_next);
  endproperty
  a_blkp_update: assert property (p_blkp_update)
    else $error("block pointer not updated");
  property p_lcmd_capture;
    cmd_exec |=> last_bus_command == $past(cmd_word) ##1
      ($past(cmd_exec) || $stable(last_bus_command));
  endproperty
  a_lcmd_capture: assert property (p_lcmd_capture)
    else $error("last command not captured");
  property p_logp_step;
    log_step && !wr_logp |=> event_log_pointer == $past(event_log_pointer) + LOG_STRIDE;
  endproperty
  a_logp_step: assert property (p_logp_step)
    else $error("log pointer did not advance");
  property p_unmapped;
    host_rd && (host_addr == 5'h03 || host_addr == 5'h0b || host_addr == 5'h1f)
      |=> host_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  c_monitor_start: cover property (mon_go ##1 mon_act);
  c_prst_done: cover property (prst_go ##[1:300] !prst_busy);
  c_log_steps: cover property (log_step ##[1:20] log_step);
endmodule : mtr_regs

//--- tb/mtr_host.sv
// host processor model driving the parallel register port
`timescale 1ns/100ps
`include "mtr_defs.svh"
module mtr_host
  import mtr_pkg::*;
(
  input wire logic core_clk,
  output mtr_addr_t host_addr,
  output logic host_wr,
  output logic host_rd,
  output mtr_word_t host_wdata
);
  initial
  begin
    host_addr = 5'h1f;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 16'h0000;
  end
  // one-cycle write strobe; data is scrambled once the strobe drops
  task automatic wr(input mtr_addr_t a, input mtr_word_t d);
    @(posedge core_clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge core_clk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
  endtask : wr
  task automatic rd(input mtr_addr_t a);
    @(posedge core_clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge core_clk);
    host_rd <= 1'b0;
  endtask : rd
  // watcher select goes in before role_select is written as zero
  task automatic enter_watch(input mtr_word_t ctrl);
    wr(`MTR_A_MCTL, 16'h8000);
    wr(`MTR_A_CTRL, ctrl & 16'hfbff);
  endtask : enter_watch
  // the log pointer is loaded with the list start
  task automatic load_log(input mtr_word_t p);
    wr(`MTR_A_LOGP, p);
  endtask : load_log
endmodule : mtr_host

//--- tb/monitor_terminal_registers_test.sv
// self-checking bench of the monitor register bank
`timescale 1ns/100ps
`include "mtr_defs.svh"
module monitor_terminal_registers_test
  import mtr_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  mtr_addr_t host_addr;
  logic host_wr, host_rd, rd_q;
  mtr_word_t host_wdata, host_rdata, watch_mask_hi;
  logic cmd_exec = 1'b0, log_entry_done = 1'b0, chan_a_active = 1'b1;
  logic subsys_fail = 1'b0, mode_select_pin = 1'b1, lock_pin = 1'b0;
  mtr_word_t cmd_word = 16'h0000, cmd_block_next = 16'h0000, urgent_evt = 16'h0000;
  logic start_enable, role_select, chan_b_enable, chan_a_enable, bc_timeout, ext_override;
  logic bus_watcher_select, watch_all, watch_selected, self_test_busy, soft_reset_busy;
  logic timer_clear;
  int failures = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h5003;
  mtr_word_t qv[$];
  string qn[$];
  mtr_word_t v, w, b, p, lo, watch_mask_lo;
  mtr_addr_t ra[7] = '{5'h02, 5'h06, 5'h07, 5'h09, 5'h0e, 5'h10, 5'h11};
  mtr_word_t rm[7] = '{16'hffff, 16'hffff, 16'h013b, 16'h0003, 16'he000, 16'hffff, 16'hffff};
  mtr_addr_t za[8] = '{5'h03, 5'h04, 5'h0f, 5'h12, 5'h1f, 5'h0b, 5'h0c, 5'h0d};

  initial
  begin
    forever #2 core_clk = ~core_clk;
  end

  mtr_host u_host (.core_clk(core_clk), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata));

  mtr_regs #(.BIT_CYCLES(20), .PRST_CYCLES(5)) u_dut (.core_clk(core_clk), .nrst(nrst),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .cmd_exec(cmd_exec), .cmd_word(cmd_word),
    .cmd_block_next(cmd_block_next), .log_entry_done(log_entry_done),
    .urgent_evt(urgent_evt), .chan_a_active(chan_a_active), .subsys_fail(subsys_fail),
    .mode_select_pin(mode_select_pin), .lock_pin(lock_pin), .start_enable(start_enable),
    .role_select(role_select), .chan_a_enable(chan_a_enable), .chan_b_enable(chan_b_enable),
    .bc_timeout(bc_timeout), .ext_override(ext_override),
    .bus_watcher_select(bus_watcher_select), .watch_all(watch_all),
    .watch_selected(watch_selected), .watch_mask_lo(watch_mask_lo),
    .watch_mask_hi(watch_mask_hi), .self_test_busy(self_test_busy),
    .soft_reset_busy(soft_reset_busy), .timer_clear(timer_clear));

  function automatic mtr_word_t rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd

  task automatic check(input string n, input mtr_word_t seen, input mtr_word_t exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  // note the expected word, then let the host read it
  task automatic ex(input mtr_addr_t a, input mtr_word_t e, input string n);
    qv.push_back(e);
    qn.push_back(n);
    u_host.rd(a);
  endtask : ex

  // read data lands one cycle after the read edge
  always @(posedge core_clk) rd_q <= host_rd;
  always @(negedge core_clk)
    if (rd_q === 1'b1)
    begin
      if (qv.size() == 0)
        check("read without note", host_rdata, 16'hxxxx);
      else
        check(qn.pop_front(), host_rdata, qv.pop_front());
    end

  initial
  begin
    #40000;
    failures++;
    finish_test();
  end

  initial
  begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    ex(`MTR_A_CTRL, 16'h0000, "control after reset");
    ex(`MTR_A_STAT, 16'h0800, "status after reset");
    for (int i = 0; i < 7; i++)
    begin
      v = rnd();
      u_host.wr(ra[i], v);
      if (ra[i] == `MTR_A_MSKL)
        lo = v;
      ex(ra[i], v & rm[i], "rw register");
    end
    @(negedge core_clk);
    check("mask high pins", watch_mask_hi, v);
    check("mask low pins", watch_mask_lo, lo);
    v = (rnd() & 16'hfffe) | 16'h0400;
    u_host.wr(`MTR_A_CTRL, v);
    @(negedge core_clk);
    check("role select", {15'h0, role_select}, 16'h0001);
    w = {10'h000, bc_timeout, ext_override, chan_b_enable, chan_a_enable, start_enable,
      role_select};
    check("control pins", w, {10'h000, v[12], v[11], v[8], v[7], v[0], v[10]});
    check("channel b", {15'h0, chan_b_enable}, {15'h0, v[8]});
    ex(`MTR_A_CTRL, v & 16'h1980, "control readback");
    u_host.wr(`MTR_A_LCMD, rnd());
    u_host.wr(`MTR_A_TADR, rnd());
    u_host.wr(`MTR_A_STAT, 16'hffff);
    u_host.wr(5'h03, rnd());
    ex(`MTR_A_LCMD, 16'h0000, "last command");
    ex(`MTR_A_TADR, 16'h0100, "terminal address");
    ex(`MTR_A_STAT, 16'h1800, "status ignores write");
    foreach (za[i]) ex(za[i], 16'h0000, "zero read");
    u_host.wr(`MTR_A_TCLR, rnd());
    @(negedge core_clk);
    check("timer clear", {15'h0, timer_clear}, 16'h0001);
    @(negedge core_clk);
    check("timer clear end", {15'h0, timer_clear}, 16'h0000);
    w = rnd();
    b = rnd();
    @(posedge core_clk);
    cmd_word <= w;
    cmd_block_next <= b;
    chan_a_active <= 1'b0;
    cmd_exec <= 1'b1;
    @(posedge core_clk);
    cmd_exec <= 1'b0;
    ex(`MTR_A_LCMD, w, "captured command");
    ex(`MTR_A_BLKP, b, "block pointer update");
    ex(`MTR_A_STAT, 16'h1000, "status channel b");
    p = rnd();
    u_host.load_log(p);
    u_host.enter_watch(16'h0181);
    @(negedge core_clk);
    v = {11'h000, bus_watcher_select, watch_all, watch_selected, start_enable, role_select};
    check("watcher pins", v, 16'h0012);
    ex(`MTR_A_STAT, 16'h8000, "watcher active");
    @(posedge core_clk);
    log_entry_done <= 1'b1;
    @(posedge core_clk);
    log_entry_done <= 1'b0;
    ex(`MTR_A_LOGP, p + `MTR_LOG_STRIDE, "log pointer advance");
    @(posedge core_clk);
    urgent_evt <= 16'hffff;
    @(posedge core_clk);
    urgent_evt <= 16'h0000;
    ex(`MTR_A_UFLG, 16'h013b, "urgent flags");
    u_host.wr(`MTR_A_UFLG, 16'h0001);
    ex(`MTR_A_UFLG, 16'h013a, "urgent clear");
    @(posedge core_clk);
    subsys_fail <= 1'b1;
    @(posedge core_clk);
    subsys_fail <= 1'b0;
    u_host.wr(`MTR_A_PRST, 16'h0001);
    ex(`MTR_A_STAT, 16'h2c00, "status in reset");
    @(negedge core_clk);
    check("start cleared", {15'h0, start_enable}, 16'h0000);
    check("reset busy", {14'h0, soft_reset_busy, self_test_busy}, 16'h0002);
    repeat (10) @(posedge core_clk);
    ex(`MTR_A_STAT, 16'h0c00, "status after reset");
    ex(`MTR_A_CTRL, 16'h0180, "control kept");
    ex(`MTR_A_LCMD, w, "command kept");
    ex(`MTR_A_BLKP, b, "block pointer kept");
    ex(`MTR_A_MSKL, 16'h0000, "mask cleared");
    @(negedge core_clk);
    check("mask low cleared", watch_mask_lo, 16'h0000);
    check("mask high cleared", watch_mask_hi, 16'h0000);
    check("reset busy done", {14'h0, soft_reset_busy, self_test_busy}, 16'h0000);
    u_host.wr(`MTR_A_BIT, 16'h0001);
    ex(`MTR_A_STAT, 16'h4c00, "self test active");
    @(negedge core_clk);
    check("test busy", {14'h0, soft_reset_busy, self_test_busy}, 16'h0001);
    repeat (30) @(posedge core_clk);
    ex(`MTR_A_STAT, 16'h0c00, "self test done");
    @(negedge core_clk);
    check("test busy end", {14'h0, soft_reset_busy, self_test_busy}, 16'h0000);
    repeat (3) @(posedge core_clk);
    check("notes left", 16'(qv.size()), 16'h0000);
    finish_test();
  end
endmodule : monitor_terminal_registers_test
